// ===== inc/jbh_pkg.sv
// Function
// [RQ1] Software marks final input slice after copying.
// [RQ2] Software sets line write-end after count update.
// [RQ3] Line write-end reads one until hardware accepts.
// [RQ4] Line pointer clear resets read/write pointers.
// [RQ5] Line space equals slice count minus write count.
// [RQ6] Software marks final stream data after copying.
// [RQ7] Stream write-end set by software, pending until accepted.
// [RQ8] Stream pointer clear resets read/write pointers.
// [RQ9] Nineteen-bit valid word count over two registers.
// [RQ10] Decode copies never exceed size minus valid.
// [RQ11] Code-count register fields: class, table, index, count.
// [RQ12] Software zeroes index before each table load.
// [RQ13] DC symbol register fields: table, index, value.
// [RQ14] AC symbol fields swap meaning by operation.
// [RQ15] Hardware clears write-end when consuming update.
// [RQ16] Encode select: one encodes, zero decodes.
// [RQ17] Software programs write count, avoids overfill.
// [RQ18] Line empty flag invites more input data.
// [RQ19] Stream full flag asks software to drain.
package jbh_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] A_SLICES = 16'h0A16;
   localparam logic [15:0] A_WCNT = 16'h0A1C;
   localparam logic [15:0] A_SSIZE_LO = 16'h0A22;
   localparam logic [15:0] A_SSIZE_HI = 16'h0A24;
   localparam logic [15:0] A_XFER_LO = 16'h0A26;
   localparam logic [15:0] A_XFER_HI = 16'h0A28;
   localparam logic [15:0] A_MODE = 16'h0AB0;
   localparam logic [15:0] A_FLAGS = 16'h0AB2;
   localparam logic [15:0] A_LB_CTRL = 16'h0AB4;
   localparam logic [15:0] A_LB_SPACE = 16'h0AB6;
   localparam logic [15:0] A_BS_CTRL = 16'h0AB8;
   localparam logic [15:0] A_BS_VLO = 16'h0ABA;
   localparam logic [15:0] A_BS_VHI = 16'h0ABC;
   localparam logic [15:0] A_HUF_CNT = 16'h0ABE;
   localparam logic [15:0] A_HUF_DC = 16'h0AC0;
   localparam logic [15:0] A_HUF_ACL = 16'h0AC2;
   localparam logic [15:0] A_HUF_ACC = 16'h0AC4;
   localparam logic [15:0] A_INT_STAT = 16'h0AD0;
   localparam logic [15:0] A_INT_MASK = 16'h0AD2;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int B_CLEAR = 0;
   localparam int B_WREND = 1;
   localparam int B_LAST = 2;
   localparam int B_ENC = 0;
   localparam int B_TRIG = 1;
   localparam int B_EMPTY = 4;
   localparam int B_FULL = 7;
   localparam int B_CNT_AC = 13;
   localparam int B_CNT_CH = 12;
   localparam int B_DC_CH = 11;
   localparam int N_EV = 4;
   localparam logic [15:0] R_ZERO = 16'h0000;

   // Huffman register selector codes.
   localparam logic [1:0] H_CNT = 2'h0;
   localparam logic [1:0] H_DC = 2'h1;
   localparam logic [1:0] H_ACL = 2'h2;
   localparam logic [1:0] H_ACC = 2'h3;

   // Events from the codec engine, one-cycle pulses.
   typedef struct packed {
      logic lb_ack;
      logic lb_slice_done;
      logic bs_ack;
      logic bs_word_done;
   } jbh_eng_t;

   // One Huffman table write, decoded for the engine.
   typedef struct packed {
      logic load;
      logic [1:0] sel;
      logic ac;
      logic chroma;
      logic [7:0] index;
      logic [7:0] value;
   } jbh_huff_t;

endpackage

// ===== design/jbh_buffer_handshake.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module jbh_buffer_handshake import jbh_pkg::*; #(
   parameter int LW = 5, // Line pointer width.
   parameter int SW = 19 // Stream pointer width.
) (
   input wire logic ref_clk, // Register clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic [15:0] reg_addr, // Register address.
   input wire logic [15:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [15:0] reg_rdata, // Read data.
   input wire jbh_eng_t eng_ev, // Engine events.
   output logic irq, // Interrupt level.
   output logic encode_select, // Operation mode.
   output logic cmd_trigger, // Command trigger mode.
   output logic final_input_slice_flag, // Last input slice.
   output logic line_store_update_req, // Line update pending.
   output logic [LW-1:0] line_wr_ptr, // Line write pointer.
   output logic [LW-1:0] line_rd_ptr, // Line read pointer.
   output logic final_stream_data_flag, // Last stream data.
   output logic stream_store_update_req, // Stream update pending.
   output logic [SW-1:0] stream_wr_ptr, // Stream write pointer.
   output logic [SW-1:0] stream_rd_ptr, // Stream read pointer.
   output jbh_huff_t huff_load // Huffman table write.
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0] rd_q, rd_d;
   logic enc_q, enc_d, trig_q, trig_d;
   logic [LW-1:0] slices_q, slices_d, wcnt_q, wcnt_d;
   logic [LW-1:0] lbw_q, lbw_d, lbr_q, lbr_d;
   logic lblast_q, lblast_d, lbpend_q, lbpend_d;
   logic [SW-1:0] ssize_q, ssize_d, xfer_q, xfer_d;
   logic [SW-1:0] bsw_q, bsw_d, bsr_q, bsr_d;
   logic bslast_q, bslast_d, bspend_q, bspend_d;
   logic empty_q, empty_d, full_q, full_d;
   logic [N_EV-1:0] ist_q, ist_d, imask_q, imask_d;
   logic irq_q, irq_d;
   logic [15:0] hcnt_q, hcnt_d, hdc_q, hdc_d;
   logic [15:0] hacl_q, hacl_d, hacc_q, hacc_d;
   jbh_huff_t huf_q, huf_d;
   logic [LW-1:0] lb_fill, lb_space;
   logic [SW-1:0] bs_valid;
   logic [N_EV-1:0] ev;

   // True when a write strobe targets the given offset.
   function automatic logic wr_at(input logic [15:0] off);
      wr_at = reg_wr && (reg_addr == off);
   endfunction

   // Splits an AC symbol word; field order depends on the mode.
   function automatic jbh_huff_t ac_split(input logic [15:0] w,
                                         input logic enc,
                                         input logic [1:0] sel);
      jbh_huff_t h;
      h = '0;
      h.load = 1'b1;
      h.sel = sel;
      h.ac = 1'b1;
      h.chroma = (sel == H_ACC);
      if (enc) begin
         h.value = w[15:8]; // see [RQ14]
         h.index = w[7:0];
      end else begin
         h.index = w[15:8]; // see [RQ14]
         h.value = w[7:0];
      end
      ac_split = h;
   endfunction

   // ----------------------------------------------------------------
   // Derived levels
   // ----------------------------------------------------------------
   // Occupancy wraps with the pointers; room is slice count minus write count.
   assign lb_fill = lbw_q - lbr_q;
   assign lb_space = slices_q - wcnt_q; // see [RQ5]
   assign bs_valid = bsw_q - bsr_q; // see [RQ9]

   // ----------------------------------------------------------------
   // Configuration and mode registers
   // ----------------------------------------------------------------
   // Plain software settings; write count is writable only when
   // software owns it, otherwise writes are ignored.
   always_comb begin
      enc_d = enc_q;
      trig_d = trig_q;
      slices_d = slices_q;
      wcnt_d = wcnt_q;
      ssize_d = ssize_q;
      xfer_d = xfer_q;
      imask_d = imask_q;
      if (wr_at(A_MODE)) begin
         enc_d = reg_wdata[B_ENC]; // see [RQ16]
         trig_d = reg_wdata[B_TRIG];
      end
      if (wr_at(A_SLICES)) begin
         slices_d = reg_wdata[LW-1:0];
      end
      if (wr_at(A_WCNT) && enc_q && trig_q) begin
         wcnt_d = reg_wdata[LW-1:0]; // see [RQ17]
      end
      if (wr_at(A_SSIZE_LO)) begin
         ssize_d[15:0] = reg_wdata;
      end
      if (wr_at(A_SSIZE_HI)) begin
         ssize_d[SW-1:16] = reg_wdata[SW-17:0];
      end
      if (wr_at(A_XFER_LO)) begin
         xfer_d[15:0] = reg_wdata;
      end
      if (wr_at(A_XFER_HI)) begin
         xfer_d[SW-1:16] = reg_wdata[SW-17:0];
      end
      if (wr_at(A_INT_MASK)) begin
         imask_d = reg_wdata[N_EV-1:0];
      end
   end

   // Registers the configuration group.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         enc_q <= 1'b0;
         trig_q <= 1'b0;
         slices_q <= '0;
         wcnt_q <= '0;
         ssize_q <= '0;
         xfer_q <= '0;
         imask_q <= '0;
      end else begin
         enc_q <= enc_d;
         trig_q <= trig_d;
         slices_q <= slices_d;
         wcnt_q <= wcnt_d;
         ssize_q <= ssize_d;
         xfer_q <= xfer_d;
         imask_q <= imask_d;
      end
   end

   // ----------------------------------------------------------------
   // Line store handshake
   // ----------------------------------------------------------------
   // An accepted update advances the write pointer by the write
   // count; a software set in the same cycle keeps the request up.
   always_comb begin
      lbw_d = lbw_q;
      lbr_d = lbr_q;
      lblast_d = lblast_q;
      lbpend_d = lbpend_q;
      if (lbpend_q && eng_ev.lb_ack) begin
         lbpend_d = 1'b0; // see [RQ15]
         lbw_d = lbw_q + wcnt_q;
      end
      if (eng_ev.lb_slice_done && (lb_fill != '0)) begin
         lbr_d = lbr_q + {{(LW-1){1'b0}}, 1'b1};
      end
      if (wr_at(A_LB_CTRL)) begin
         lblast_d = reg_wdata[B_LAST]; // see [RQ1]
         if (reg_wdata[B_WREND]) begin
            lbpend_d = 1'b1; // see [RQ2] [RQ3]
         end
         if (reg_wdata[B_CLEAR]) begin
            lbw_d = '0; // see [RQ4]
            lbr_d = '0;
            lbpend_d = 1'b0;
         end
      end
   end

   // Registers the line store group.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lbw_q <= '0;
         lbr_q <= '0;
         lblast_q <= 1'b0;
         lbpend_q <= 1'b0;
      end else begin
         lbw_q <= lbw_d;
         lbr_q <= lbr_d;
         lblast_q <= lblast_d;
         lbpend_q <= lbpend_d;
      end
   end

   // ----------------------------------------------------------------
   // Stream store handshake
   // ----------------------------------------------------------------
   // Encode: engine fills, software drains by the transfer size.
   // Decode: software fills by the transfer size, engine drains.
   always_comb begin
      bsw_d = bsw_q;
      bsr_d = bsr_q;
      bslast_d = bslast_q;
      bspend_d = bspend_q;
      if (bspend_q && eng_ev.bs_ack) begin
         bspend_d = 1'b0; // see [RQ15]
         if (enc_q) begin
            bsr_d = bsr_q + xfer_q; // see [RQ7]
         end else begin
            bsw_d = bsw_q + xfer_q; // see [RQ10]
         end
      end
      if (eng_ev.bs_word_done) begin
         if (enc_q) begin
            bsw_d = bsw_d + {{(SW-1){1'b0}}, 1'b1};
         end else if (bs_valid != '0) begin
            bsr_d = bsr_d + {{(SW-1){1'b0}}, 1'b1};
         end
      end
      if (wr_at(A_BS_CTRL)) begin
         bslast_d = reg_wdata[B_LAST]; // see [RQ6]
         if (reg_wdata[B_WREND]) begin
            bspend_d = 1'b1; // see [RQ7]
         end
         if (reg_wdata[B_CLEAR]) begin
            bsw_d = '0; // see [RQ8]
            bsr_d = '0;
            bspend_d = 1'b0;
         end
      end
   end

   // Registers the stream store group.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bsw_q <= '0;
         bsr_q <= '0;
         bslast_q <= 1'b0;
         bspend_q <= 1'b0;
      end else begin
         bsw_q <= bsw_d;
         bsr_q <= bsr_d;
         bslast_q <= bslast_d;
         bspend_q <= bspend_d;
      end
   end

   // ----------------------------------------------------------------
   // Flags and interrupts
   // ----------------------------------------------------------------
   // Sticky events: accepts and rising empty or full; a new event
   // beats a write-one clear in the same cycle.
   always_comb begin
      empty_d = enc_q && trig_q && (lbw_d == lbr_d); // see [RQ18]
      full_d = enc_q && ((bsw_d - bsr_d) >= ssize_q); // see [RQ19]
      ev[0] = lbpend_q && eng_ev.lb_ack;
      ev[1] = bspend_q && eng_ev.bs_ack;
      ev[2] = empty_d && !empty_q;
      ev[3] = full_d && !full_q;
      ist_d = ist_q;
      if (wr_at(A_INT_STAT)) begin
         ist_d = ist_q & ~reg_wdata[N_EV-1:0];
      end
      ist_d = ist_d | ev;
      irq_d = |(ist_d & imask_d);
   end

   // Registers the flag group.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         empty_q <= 1'b0;
         full_q <= 1'b0;
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         empty_q <= empty_d;
         full_q <= full_d;
         ist_q <= ist_d;
         irq_q <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // Huffman table loading
   // ----------------------------------------------------------------
   // Each write is held for read-back and passed to the engine as a
   // one-cycle load carrying decoded fields.
   always_comb begin
      hcnt_d = hcnt_q;
      hdc_d = hdc_q;
      hacl_d = hacl_q;
      hacc_d = hacc_q;
      huf_d = '0;
      if (wr_at(A_HUF_CNT)) begin
         hcnt_d = reg_wdata & 16'h3FFF;
         huf_d.load = 1'b1;
         huf_d.sel = H_CNT;
         huf_d.ac = reg_wdata[B_CNT_AC]; // see [RQ11]
         huf_d.chroma = reg_wdata[B_CNT_CH];
         huf_d.index = {4'h0, reg_wdata[11:8]}; // see [RQ12]
         huf_d.value = reg_wdata[7:0];
      end
      if (wr_at(A_HUF_DC)) begin
         hdc_d = reg_wdata & 16'h0FFF;
         huf_d.load = 1'b1;
         huf_d.sel = H_DC;
         huf_d.chroma = reg_wdata[B_DC_CH]; // see [RQ13]
         huf_d.index = {5'h00, reg_wdata[10:8]};
         huf_d.value = reg_wdata[7:0];
      end
      if (wr_at(A_HUF_ACL)) begin
         hacl_d = reg_wdata;
         huf_d = ac_split(reg_wdata, enc_q, H_ACL);
      end
      if (wr_at(A_HUF_ACC)) begin
         hacc_d = reg_wdata;
         huf_d = ac_split(reg_wdata, enc_q, H_ACC);
      end
   end

   // Registers the Huffman group.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hcnt_q <= R_ZERO;
         hdc_q <= R_ZERO;
         hacl_q <= R_ZERO;
         hacc_q <= R_ZERO;
         huf_q <= '0;
      end else begin
         hcnt_q <= hcnt_d;
         hdc_q <= hdc_d;
         hacl_q <= hacl_d;
         hacc_q <= hacc_d;
         huf_q <= huf_d;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Data stands in the cycle after the strobe only; unmapped reads
   // return zero.
   always_comb begin
      rd_d = R_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            A_SLICES: rd_d = {11'h000, slices_q};
            A_WCNT: rd_d = {11'h000, wcnt_q};
            A_SSIZE_LO: rd_d = ssize_q[15:0];
            A_SSIZE_HI: rd_d = {13'h0000, ssize_q[SW-1:16]};
            A_XFER_LO: rd_d = xfer_q[15:0];
            A_XFER_HI: rd_d = {13'h0000, xfer_q[SW-1:16]};
            A_MODE: rd_d = {14'h0000, trig_q, enc_q};
            A_FLAGS: begin
               rd_d[B_EMPTY] = empty_q;
               rd_d[B_FULL] = full_q;
            end
            A_LB_CTRL: rd_d = {13'h0000, lblast_q, lbpend_q, 1'b0}; // see [RQ3]
            A_LB_SPACE: rd_d = {11'h000, lb_space}; // see [RQ5]
            A_BS_CTRL: rd_d = {13'h0000, bslast_q, bspend_q, 1'b0}; // see [RQ7]
            A_BS_VLO: rd_d = bs_valid[15:0]; // see [RQ9]
            A_BS_VHI: rd_d = {13'h0000, bs_valid[SW-1:16]};
            A_HUF_CNT: rd_d = hcnt_q;
            A_HUF_DC: rd_d = hdc_q;
            A_HUF_ACL: rd_d = hacl_q;
            A_HUF_ACC: rd_d = hacc_q;
            A_INT_STAT: rd_d = {12'h000, ist_q};
            A_INT_MASK: rd_d = {12'h000, imask_q};
            default: rd_d = R_ZERO;
         endcase
      end
   end

   // Registers the read data.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_q <= R_ZERO;
      end else begin
         rd_q <= rd_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rd_q;
   assign irq = irq_q;
   assign encode_select = enc_q;
   assign cmd_trigger = trig_q;
   assign final_input_slice_flag = lblast_q;
   assign line_store_update_req = lbpend_q;
   assign line_wr_ptr = lbw_q;
   assign line_rd_ptr = lbr_q;
   assign final_stream_data_flag = bslast_q;
   assign stream_store_update_req = bspend_q;
   assign stream_wr_ptr = bsw_q;
   assign stream_rd_ptr = bsr_q;
   assign huff_load = huf_q;

endmodule // jbh_buffer_handshake
`default_nettype wire

// ===== dv/jbh_buffer_handshake_props.sv
`timescale 1ns/1ps
`default_nettype none
module jbh_buffer_handshake_props import jbh_pkg::*; #(
   parameter int LW = 5, // Line width.
   parameter int SW = 19 // Stream width.
) (
   input wire logic ref_clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic [15:0] reg_addr, // Address.
   input wire logic [15:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   input wire logic [15:0] reg_rdata, // Read data.
   input wire jbh_eng_t eng_ev, // Engine events.
   input wire logic irq, // Interrupt.
   input wire logic encode_select, // Mode.
   input wire logic cmd_trigger, // Trigger mode.
   input wire logic final_input_slice_flag, // Last slice.
   input wire logic line_store_update_req, // Line pending.
   input wire logic [LW-1:0] line_wr_ptr, // Line write pointer.
   input wire logic [LW-1:0] line_rd_ptr, // Line read pointer.
   input wire logic final_stream_data_flag, // Last stream data.
   input wire logic stream_store_update_req, // Stream pending.
   input wire logic [SW-1:0] stream_wr_ptr, // Stream write pointer.
   input wire logic [SW-1:0] stream_rd_ptr, // Stream read pointer.
   input wire jbh_huff_t huff_load // Huffman write.
);
   // Decoded writes, and the write data and mode of the previous cycle.
   wire logic lb_wr = reg_wr && reg_addr == A_LB_CTRL;
   wire logic bs_wr = reg_wr && reg_addr == A_BS_CTRL;
   wire logic hf_wr = reg_wr && reg_addr inside {A_HUF_CNT, A_HUF_DC, A_HUF_ACL, A_HUF_ACC};
   logic [15:0] wd_q;
   logic enc_q;
   // Registers the data that the one-cycle-late checks compare with.
   always_ff @(posedge ref_clk) begin
      wd_q <= reg_wdata;
      enc_q <= encode_select;
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("Idle read data.");
   property p_lb_set; lb_wr && reg_wdata[1] && !reg_wdata[0] |=> line_store_update_req; endproperty
   a_lb_set: assert property (p_lb_set) else $error("Line update lost.");
   property p_lb_hold; line_store_update_req && !eng_ev.lb_ack && !(lb_wr && reg_wdata[0])
      |=> line_store_update_req; endproperty
   a_lb_hold: assert property (p_lb_hold) else $error("Line update dropped.");
   property p_lb_ack; line_store_update_req && eng_ev.lb_ack && !lb_wr |=> !line_store_update_req;
   endproperty
   a_lb_ack: assert property (p_lb_ack) else $error("Line update kept.");
   property p_lb_clr; lb_wr && reg_wdata[0] |=> line_wr_ptr == '0 && line_rd_ptr == '0;
   endproperty
   a_lb_clr: assert property (p_lb_clr) else $error("Line pointers kept.");
   property p_bs_set; bs_wr && reg_wdata[1] && !reg_wdata[0] |=> stream_store_update_req;
   endproperty
   a_bs_set: assert property (p_bs_set) else $error("Stream update lost.");
   property p_bs_ack; stream_store_update_req && eng_ev.bs_ack && !bs_wr ##1 !bs_wr
      |-> !stream_store_update_req ##1 !stream_store_update_req; endproperty
   a_bs_ack: assert property (p_bs_ack) else $error("Stream update kept.");
   property p_bs_clr; bs_wr && reg_wdata[0] |=> stream_wr_ptr == '0 && stream_rd_ptr == '0;
   endproperty
   a_bs_clr: assert property (p_bs_clr) else $error("Stream pointers kept.");
   property p_word; eng_ev.bs_word_done && encode_select && !bs_wr
      |=> stream_wr_ptr == $past(stream_wr_ptr) + 1'b1; endproperty
   a_word: assert property (p_word) else $error("Stream word not counted.");
   property p_huf; hf_wr |=> huff_load.load; endproperty
   a_huf: assert property (p_huf) else $error("Huffman load missing.");
   property p_ac; reg_wr && reg_addr == A_HUF_ACL
      |=> huff_load.value == (enc_q ? wd_q[15:8] : wd_q[7:0]); endproperty
   a_ac: assert property (p_ac) else $error("AC field order wrong.");
   property p_mode; reg_wr && reg_addr == A_MODE |=> encode_select == wd_q[0]; endproperty
   a_mode: assert property (p_mode) else $error("Mode not taken.");
   c_lb_ack: cover property (line_store_update_req && eng_ev.lb_ack);
   c_bs_clr: cover property (bs_wr && reg_wdata[0]);
   c_huf: cover property (huff_load.load && !encode_select);
endmodule // jbh_buffer_handshake_props
`default_nettype wire

// ===== dv/jbh_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module jbh_engine_model import jbh_pkg::*; (
   input wire logic ref_clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic line_req, // Line update pending.
   input wire logic stream_req, // Stream update pending.
   input wire logic [3:0] ack_delay, // Wait before accepting.
   input wire logic lb_tick, // Consume one slice.
   input wire logic bs_tick, // Move one stream word.
   output jbh_eng_t eng_ev // Engine events.
);
   logic [3:0] lw_q, lw_d, sw_q, sw_d;
   jbh_eng_t ev_d;
   // An update is accepted once posted and after the chosen wait.
   always_comb begin
      ev_d.lb_ack = line_req && !eng_ev.lb_ack && lw_q >= ack_delay;
      ev_d.bs_ack = stream_req && !eng_ev.bs_ack && sw_q >= ack_delay;
      ev_d.lb_slice_done = lb_tick;
      ev_d.bs_word_done = bs_tick;
      lw_d = (line_req && !ev_d.lb_ack) ? lw_q + 4'h1 : 4'h0;
      sw_d = (stream_req && !ev_d.bs_ack) ? sw_q + 4'h1 : 4'h0;
   end
   // Registers the wait counters and the event pulses.
   always_ff @(posedge ref_clk) begin
      lw_q <= sys_rst ? 4'h0 : lw_d;
      sw_q <= sys_rst ? 4'h0 : sw_d;
      eng_ev <= sys_rst ? '0 : ev_d;
   end
endmodule // jbh_engine_model
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import jbh_pkg::*; ;
   logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, lb_tick = 1'b0;
   logic bs_tick = 1'b0, irq, enc, trig, fin_l, lreq, fin_s, sreq;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rd_v, d;
   logic [3:0] ack_delay = 4'h4;
   logic [4:0] lwp, lrp;
   logic [18:0] swp, srp;
   logic [7:0] ei, ev;
   jbh_eng_t eng_ev;
   jbh_huff_t huff_load;
   int err_total = 0, cmp_count = 0, seed = 21, w, i, k;
   logic [15:0] ra [10] = '{A_LB_CTRL, A_LB_SPACE, A_BS_CTRL, A_BS_VLO, A_BS_VHI, A_HUF_CNT,
      A_HUF_DC, A_HUF_ACL, A_HUF_ACC, 16'h0AFE};
   logic [15:0] ha [4] = '{A_HUF_CNT, A_HUF_DC, A_HUF_ACL, A_HUF_ACC};
   logic [15:0] hm [4] = '{16'h3FFF, 16'h0FFF, 16'hFFFF, 16'hFFFF};
   // Design and engine model.
   jbh_buffer_handshake dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .eng_ev(eng_ev), .irq(irq), .encode_select(enc), .cmd_trigger(trig),
      .final_input_slice_flag(fin_l), .line_store_update_req(lreq), .line_wr_ptr(lwp),
      .line_rd_ptr(lrp), .final_stream_data_flag(fin_s), .stream_store_update_req(sreq),
      .stream_wr_ptr(swp), .stream_rd_ptr(srp), .huff_load(huff_load));
   jbh_engine_model eng_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .line_req(lreq),
      .stream_req(sreq), .ack_delay(ack_delay), .lb_tick(lb_tick), .bs_tick(bs_tick),
      .eng_ev(eng_ev));
   // Clock of 100 MHz.
   always #5 ref_clk = ~ref_clk;
   // Compares one result with the expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // One write cycle, then one idle edge.
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   // One read cycle; the data is taken in the cycle after it.
   task automatic rd(input logic [15:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      rd_v = reg_rdata;
   endtask
   // Polls a control register until the update flag reads zero.
   task automatic poll(input logic [15:0] a);
      int n;
      for (n = 0; n < 40 && (n == 0 || rd_v[1] !== 1'b0); n++) begin
         rd(a);
      end
      if (rd_v[1] !== 1'b0) begin
         err_total++;
         end_sim();
      end
   endtask
   // Prints the verdict and stops.
   task automatic end_sim();
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      wr(16'h0AFE, 16'hFFFF);
      wr(A_WCNT, 16'h0005);
      for (i = 0; i < 10; i++) begin
         rd(ra[i]);
         chk(rd_v, 32'h0);
      end
      wr(A_MODE, 16'h0003);
      wr(A_SLICES, 16'h0010);
      w = 2 + $unsigned($random(seed)) % 14;
      ack_delay <= 4'($unsigned($random(seed)) % 8 + 4);
      wr(A_WCNT, 16'(w));
      rd(A_LB_SPACE);
      chk(rd_v, 32'(16 - w));
      rd(A_FLAGS);
      chk(rd_v[B_EMPTY], 1);
      wr(A_LB_CTRL, 16'h0006);
      rd(A_LB_CTRL);
      chk(rd_v, 32'h6);
      chk({fin_l, trig, enc}, 3'h7);
      chk(irq, 0);
      poll(A_LB_CTRL);
      chk({rd_v, 11'h0, lwp}, {16'h0004, 11'h0, 5'(w)});
      wr(A_INT_MASK, 16'h0001);
      chk(irq, 1);
      wr(A_INT_STAT, 16'h0001);
      chk(irq, 0);
      rd(A_FLAGS);
      chk(rd_v[B_EMPTY], 0);
      lb_tick <= 1'b1;
      repeat (2) @(posedge ref_clk);
      lb_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(lrp, 2);
      wr(A_LB_CTRL, 16'h0001);
      chk({lwp, lrp}, 0);
      wr(A_SSIZE_LO, 16'h0008);
      bs_tick <= 1'b1;
      repeat (8) @(posedge ref_clk);
      bs_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(A_BS_VLO);
      chk(rd_v, 8);
      rd(A_FLAGS);
      chk(rd_v[B_FULL], 1);
      wr(A_XFER_LO, 16'h0003);
      wr(A_BS_CTRL, 16'h0006);
      rd(A_BS_CTRL);
      chk({rd_v[2:1], fin_s}, 3'h7);
      poll(A_BS_CTRL);
      chk(srp, 3);
      rd(A_BS_VLO);
      chk(rd_v, 5);
      rd(A_FLAGS);
      chk(rd_v[B_FULL], 0);
      wr(A_BS_CTRL, 16'h0001);
      chk({swp, srp}, 0);
      wr(A_MODE, 16'h0000);
      wr(A_SSIZE_HI, 16'h0007);
      wr(A_XFER_LO, 16'h0000);
      wr(A_XFER_HI, 16'h0001);
      wr(A_BS_CTRL, 16'h0002);
      poll(A_BS_CTRL);
      rd(A_BS_VHI);
      chk(rd_v, 1);
      rd(A_BS_VLO);
      chk(rd_v, 0);
      for (i = 0; i < 8; i++) begin
         k = i % 4;
         if (k == 0) wr(A_MODE, i < 4 ? 16'h0001 : 16'h0000);
         d = 16'($random(seed));
         if (k == 0) d[11:8] = 4'h0;
         wr(ha[k], d);
         ei = (k == 0) ? {4'h0, d[11:8]} : (k == 1) ? {5'h0, d[10:8]} : (i < 4) ? d[7:0] : d[15:8];
         ev = (k < 2 || i >= 4) ? d[7:0] : d[15:8];
         chk({huff_load.load, huff_load.sel, ei, ev},
            {1'b1, 2'(k), huff_load.index, huff_load.value});
         if (k < 2) chk(huff_load.chroma, k ? d[11] : d[12]);
         if (k == 0) chk(huff_load.ac, d[13]);
         rd(ha[k]);
         chk(rd_v, d & hm[k]);
      end
      end_sim();
   end
endmodule // testbench
bind jbh_buffer_handshake jbh_buffer_handshake_props #(.LW(LW), .SW(SW)) u_props (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_ev(eng_ev), .irq(irq),
   .encode_select(encode_select), .cmd_trigger(cmd_trigger),
   .final_input_slice_flag(final_input_slice_flag), .line_store_update_req(line_store_update_req),
   .line_wr_ptr(line_wr_ptr), .line_rd_ptr(line_rd_ptr),
   .final_stream_data_flag(final_stream_data_flag),
   .stream_store_update_req(stream_store_update_req), .stream_wr_ptr(stream_wr_ptr),
   .stream_rd_ptr(stream_rd_ptr), .huff_load(huff_load));
`default_nettype wire
